// ### inc/srv_cmd_map.svh
`ifndef SRV_CMD_MAP_SVH
`define SRV_CMD_MAP_SVH

// Command codes and data numbers
`define SRV_CMD_READ_MODE   8'h00
`define SRV_CMD_READ_ALARM  8'h02
`define SRV_CMD_HISTORY     8'h33
`define SRV_CMD_CLEAR       8'h82
`define SRV_CMD_MODE        8'h8b
`define SRV_CMD_IO_DISABLE  8'h90
`define SRV_CMD_FORCE       8'h92
`define SRV_CMD_POS         8'ha0
`define SRV_DNO_00          8'h00
`define SRV_DNO_03          8'h03
`define SRV_DNO_10          8'h10
`define SRV_DNO_12          8'h12
`define SRV_DNO_13          8'h13
`define SRV_DNO_20          8'h20
`define SRV_DNO_41          8'h41
`define SRV_DNO_A0          8'ha0
// Key and text data
`define SRV_KEY             32'h00001ea5
`define SRV_TXT_STOP        32'h53544f50
`define SRV_TXT_GO          32'h474f2020
`define SRV_TXT_CLR         32'h434c5220
// Values and layouts
`define SRV_NO_ALARM        16'h00ff
`define SRV_HIST_DEPTH      6
`define SRV_DI_USED         32'h0810ffff
`define SRV_STROKE_BITS     32'h00000006
`define SRV_DO_PINS         7
// Silence limit
`define SRV_SILENCE_MS      500
`define SRV_CLK_MHZ         100
`define SRV_SILENCE_CYC     (`SRV_SILENCE_MS * 1000 * `SRV_CLK_MHZ)
`endif

// ### inc/srv_pkg.sv
package srv_pkg;
  // Test operation mode, code is the read-back value
  typedef enum logic [2:0] {
    SRV_MODE_NORMAL = 3'h0,
    SRV_MODE_JOG    = 3'h1,
    SRV_MODE_POS    = 3'h2,
    SRV_MODE_NOMTR  = 3'h3,
    SRV_MODE_FORCE  = 3'h4
  } srv_mode_t;
  // Positioning sequence
  typedef enum logic [2:0] {
    SRV_POS_IDLE  = 3'b001,
    SRV_POS_RUN   = 3'b010,
    SRV_POS_PAUSE = 3'b100
  } srv_pos_t;
  // Master request sequence
  typedef enum logic [1:0] {
    SRV_MST_IDLE = 2'b01,
    SRV_MST_WAIT = 2'b10
  } srv_mst_t;
endpackage

// ### inc/srv_link_if.sv
`timescale 1ns/10ps
interface srv_link_if;
  logic        req_valid;
  logic [7:0]  req_cmd;
  logic [7:0]  req_dno;
  logic [31:0] req_data;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  modport dev (input req_valid, req_cmd, req_dno, req_data, output rsp_valid, rsp_data);
  modport mst (output req_valid, req_cmd, req_dno, req_data, input rsp_valid, rsp_data);
endinterface

// ### hdl/srv_dev.sv
`timescale 1ns/10ps
`include "srv_cmd_map.svh"
module srv_dev #(
  parameter int unsigned SILENCE_CYC = `SRV_SILENCE_CYC
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Command link
  srv_link_if.dev          link,
  // Real input sources
  input  wire logic        emergency_stop_in,
  input  wire logic [31:0] ext_di_in,
  input  wire logic [15:0] analog_in,
  input  wire logic        pulse_in,
  // Servo state
  input  wire logic        running_in,
  input  wire logic        pos_start_in,
  input  wire logic        pos_done_in,
  input  wire logic [6:0]  servo_do_in,
  // Alarm sources
  input  wire logic        alarm_event_in,
  input  wire logic [15:0] alarm_code_in,
  input  wire logic [15:0] alarm_hours_in,
  input  wire logic [15:0] alarm_now_in,
  // Recognised inputs
  output logic             emg_out,
  output logic [31:0]      discrete_inputs_out,
  output logic [15:0]      analog_out,
  output logic             pulse_out,
  // Motion control
  output logic             base_off_out,
  output logic             decel_stop_out,
  output logic             pos_pause_out,
  output logic             pos_clear_out,
  output srv_pkg::srv_mode_t mode_out,
  // Output pins
  output logic [6:0]       out_pins_out
);
  import srv_pkg::*;

  logic            in_dis_r;
  logic            out_dis_r;
  srv_mode_t       mode_r;
  srv_pos_t        pos_r;
  logic [31:0]     test_di_r;
  logic [6:0]      force_do_r;
  logic [31:0]     silence_r;
  logic [15:0]     hist_code_r [`SRV_HIST_DEPTH];
  logic [15:0]     hist_hours_r [`SRV_HIST_DEPTH];
  logic            rsp_valid_r;
  logic [31:0]     rsp_data_r;
  logic            key_ok;
  logic            hist_clr;
  logic            mode_wr;
  logic            req;

  assign req      = link.req_valid;
  assign key_ok   = (link.req_data == `SRV_KEY);
  assign mode_wr  = req && link.req_cmd == `SRV_CMD_MODE && link.req_dno == `SRV_DNO_00
                    && link.req_data <= 32'h00000004;
  assign hist_clr = req && link.req_cmd == `SRV_CMD_CLEAR && link.req_dno == `SRV_DNO_20
                    && key_ok;

  // Input and output group disable, key checked
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      in_dis_r  <= 1'b0;
      out_dis_r <= 1'b0;
    end else if (req && link.req_cmd == `SRV_CMD_IO_DISABLE && key_ok) begin
      if (link.req_dno == `SRV_DNO_00) begin
        in_dis_r <= 1'b1;
      end else if (link.req_dno == `SRV_DNO_10) begin
        in_dis_r <= 1'b0;
      end else if (link.req_dno == `SRV_DNO_03) begin
        out_dis_r <= 1'b1;
      end else if (link.req_dno == `SRV_DNO_13) begin
        out_dis_r <= 1'b0;
      end
    end
  end

  // Last written masks stand until the next write
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      test_di_r  <= 32'h0;
      force_do_r <= 7'h0;
    end else if (req && link.req_cmd == `SRV_CMD_FORCE) begin
      if (link.req_dno == `SRV_DNO_00) begin
        test_di_r <= link.req_data & `SRV_DI_USED;
      end else if (link.req_dno == `SRV_DNO_A0) begin
        force_do_r <= link.req_data[`SRV_DO_PINS-1:0];
      end
    end
  end

  // Mode select; out-of-range values are dropped
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_r <= SRV_MODE_NORMAL;
    end else if (mode_wr) begin
      mode_r <= srv_mode_t'(link.req_data[2:0]);
    end
  end

  // Base circuit cut on entry while running, held until normal mode
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      base_off_out <= 1'b0;
    end else if (mode_wr && link.req_data != 32'h0 && mode_r == SRV_MODE_NORMAL
                 && running_in) begin
      base_off_out <= 1'b1;
    end else if (mode_wr && link.req_data == 32'h0) begin
      base_off_out <= 1'b0;
    end
  end

  // Silence watchdog; counter saturates so it never wraps back
  always_ff @(posedge mclk_in) begin
    if (rst_in || req || mode_r == SRV_MODE_NORMAL) begin
      silence_r <= 32'h0;
    end else if (silence_r <= SILENCE_CYC) begin
      silence_r <= silence_r + 32'h1;
    end
  end

  // Stop and servo lock after silence, released on leaving test
  always_ff @(posedge mclk_in) begin
    if (rst_in || mode_r == SRV_MODE_NORMAL) begin
      decel_stop_out <= 1'b0;
    end else if (silence_r > SILENCE_CYC) begin
      decel_stop_out <= 1'b1;
    end
  end

  // Positioning sequence with stop, restart and clear
  always_ff @(posedge mclk_in) begin
    if (rst_in || mode_r != SRV_MODE_POS) begin
      pos_r         <= SRV_POS_IDLE;
      pos_clear_out <= 1'b0;
    end else begin
      pos_clear_out <= 1'b0;
      case (pos_r)
        SRV_POS_IDLE: begin
          if (pos_start_in) begin
            pos_r <= SRV_POS_RUN;
          end
        end
        SRV_POS_RUN: begin
          if (req && link.req_cmd == `SRV_CMD_POS && link.req_dno == `SRV_DNO_41
              && link.req_data == `SRV_TXT_STOP) begin
            pos_r <= SRV_POS_PAUSE;
          end else if (pos_done_in) begin
            pos_r <= SRV_POS_IDLE;
          end
        end
        SRV_POS_PAUSE: begin
          if (req && link.req_cmd == `SRV_CMD_POS && link.req_dno == `SRV_DNO_41) begin
            if (link.req_data == `SRV_TXT_GO) begin
              pos_r <= SRV_POS_RUN;
            end else if (link.req_data == `SRV_TXT_CLR) begin
              pos_r         <= SRV_POS_IDLE;
              pos_clear_out <= 1'b1;
            end
          end
        end
        default: begin
          pos_r <= SRV_POS_IDLE;
        end
      endcase
    end
  end

  // History shift; a clear in the same cycle as a new alarm keeps the alarm
  generate
    for (genvar i = 0; i < `SRV_HIST_DEPTH; i++) begin : g_hist
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          hist_code_r[i]  <= `SRV_NO_ALARM;
          hist_hours_r[i] <= 16'h0;
        end else if (alarm_event_in) begin
          hist_code_r[i]  <= (i == 0) ? alarm_code_in : hist_code_r[i == 0 ? 0 : i-1];
          hist_hours_r[i] <= (i == 0) ? alarm_hours_in : hist_hours_r[i == 0 ? 0 : i-1];
          if (hist_clr && i != 0) begin
            hist_code_r[i]  <= `SRV_NO_ALARM;
            hist_hours_r[i] <= 16'h0;
          end
        end else if (hist_clr) begin
          hist_code_r[i]  <= `SRV_NO_ALARM;
          hist_hours_r[i] <= 16'h0;
        end
      end
    end
  endgenerate

  // One answer per request, next cycle; unknown reads answer zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= 32'h0;
    end else begin
      rsp_valid_r <= req;
      rsp_data_r  <= 32'h0;
      if (req) begin
        if (link.req_cmd == `SRV_CMD_READ_MODE && link.req_dno == `SRV_DNO_12) begin
          rsp_data_r <= {29'h0, mode_r};
        end else if (link.req_cmd == `SRV_CMD_READ_ALARM && link.req_dno == `SRV_DNO_00) begin
          rsp_data_r <= {16'h0, alarm_now_in};
        end else if (link.req_cmd == `SRV_CMD_HISTORY && link.req_dno[7:4] == 4'h1
                     && link.req_dno[3:0] < 4'h6) begin
          rsp_data_r <= {16'h0, hist_code_r[link.req_dno[2:0]]};
        end else if (link.req_cmd == `SRV_CMD_HISTORY && link.req_dno[7:4] == 4'h2
                     && link.req_dno[3:0] < 4'h6) begin
          rsp_data_r <= {16'h0, hist_hours_r[link.req_dno[2:0]]};
        end
      end
    end
  end
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_data  = rsp_data_r;

  // Recognised inputs; test mask replaces the pins except the stroke bits during test operation
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      emg_out             <= 1'b0;
      discrete_inputs_out <= 32'h0;
      analog_out          <= 16'h0;
      pulse_out           <= 1'b0;
    end else begin
      emg_out <= emergency_stop_in;
      discrete_inputs_out <= ((in_dis_r ? 32'h0 :
                              (mode_r != SRV_MODE_NORMAL ? test_di_r : ext_di_in))
                              & ~`SRV_STROKE_BITS)
                             | (ext_di_in & `SRV_STROKE_BITS);
      analog_out <= in_dis_r ? 16'h0 : analog_in;
      pulse_out  <= in_dis_r ? 1'b0 : pulse_in;
    end
  end

  // Pins from commanded bits in forced mode, else servo state unless disabled
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_pins_out <= 7'h0;
    end else if (mode_r == SRV_MODE_FORCE) begin
      out_pins_out <= force_do_r;
    end else begin
      out_pins_out <= out_dis_r ? 7'h0 : servo_do_in;
    end
  end

  // Status mirrors
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pos_pause_out <= 1'b0;
      mode_out      <= SRV_MODE_NORMAL;
    end else begin
      pos_pause_out <= (pos_r == SRV_POS_PAUSE);
      mode_out      <= mode_r;
    end
  end
endmodule

// ### hdl/srv_mst.sv
`timescale 1ns/10ps
`include "srv_cmd_map.svh"
module srv_mst (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Command link
  srv_link_if.mst          link,
  // User request
  input  wire logic        go_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic [7:0]  dno_in,
  input  wire logic [31:0] data_in,
  // User answer
  output logic             busy_out,
  output logic             refused_out,
  output logic             rsp_valid_out,
  output logic [31:0]      rsp_data_out
);
  import srv_pkg::*;

  srv_mst_t    st_r;
  logic        req_valid_r;
  logic [7:0]  req_cmd_r;
  logic [7:0]  req_dno_r;
  logic [31:0] req_data_r;
  logic        out_dis_r;
  logic        force_wr;

  assign force_wr = cmd_in == `SRV_CMD_FORCE && dno_in == `SRV_DNO_A0;

  // Tracks output disable state sent to the device
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_dis_r <= 1'b0;
    end else if (st_r == SRV_MST_IDLE && go_in && cmd_in == `SRV_CMD_IO_DISABLE
                 && data_in == `SRV_KEY) begin
      if (dno_in == `SRV_DNO_03) begin
        out_dis_r <= 1'b1;
      end else if (dno_in == `SRV_DNO_13) begin
        out_dis_r <= 1'b0;
      end
    end
  end

  // One outstanding request; forced writes are refused until outputs disabled
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_r          <= SRV_MST_IDLE;
      req_valid_r   <= 1'b0;
      req_cmd_r     <= 8'h0;
      req_dno_r     <= 8'h0;
      req_data_r    <= 32'h0;
      busy_out      <= 1'b0;
      refused_out   <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= 32'h0;
    end else begin
      req_valid_r   <= 1'b0;
      refused_out   <= 1'b0;
      rsp_valid_out <= 1'b0;
      case (st_r)
        SRV_MST_IDLE: begin
          if (go_in && force_wr && !out_dis_r) begin
            refused_out <= 1'b1;
          end else if (go_in) begin
            st_r        <= SRV_MST_WAIT;
            req_valid_r <= 1'b1;
            req_cmd_r   <= cmd_in;
            req_dno_r   <= dno_in;
            req_data_r  <= data_in;
            busy_out    <= 1'b1;
          end
        end
        SRV_MST_WAIT: begin
          if (link.rsp_valid) begin
            st_r          <= SRV_MST_IDLE;
            busy_out      <= 1'b0;
            rsp_valid_out <= 1'b1;
            rsp_data_out  <= link.rsp_data;
          end
        end
        default: begin
          st_r <= SRV_MST_IDLE;
        end
      endcase
    end
  end
  assign link.req_valid = req_valid_r;
  assign link.req_cmd   = req_cmd_r;
  assign link.req_dno   = req_dno_r;
  assign link.req_data  = req_data_r;
endmodule

// ### bench/srv_link_sva.sv
`timescale 1ns/10ps
`include "srv_cmd_map.svh"
module srv_link_sva (
  // Clock and reset
  input wire logic        mclk_in,
  input wire logic        rst_in,
  // Link signals
  input wire logic        req_valid,
  input wire logic [7:0]  req_cmd,
  input wire logic [7:0]  req_dno,
  input wire logic [31:0] req_data,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data
);
  logic out_dis_r;
  logic key_w;
  logic frc_w;

  // Keyed disable requests and forced writes
  assign key_w = req_valid && req_cmd == `SRV_CMD_IO_DISABLE && req_data == `SRV_KEY;
  assign frc_w = req_valid && req_cmd == `SRV_CMD_FORCE && req_dno == `SRV_DNO_A0;

  // Output disable as seen on the wire, kept apart from the master's own copy
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_dis_r <= 1'b0;
    end else if (key_w && req_dno == `SRV_DNO_03) begin
      out_dis_r <= 1'b1;
    end else if (key_w && req_dno == `SRV_DNO_13) begin
      out_dis_r <= 1'b0;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_answer; req_valid |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_only; rsp_valid |-> $past(req_valid); endproperty
  a_only: assert property (p_only) else $error("answer without request");
  property p_dis_ack; req_valid && req_cmd == `SRV_CMD_IO_DISABLE |=> rsp_data == 32'h0; endproperty
  a_dis_ack: assert property (p_dis_ack) else $error("disable answer not zero");
  property p_sel_ack; req_valid && req_cmd == `SRV_CMD_MODE |=> rsp_valid && rsp_data == 32'h0;
  endproperty
  a_sel_ack: assert property (p_sel_ack) else $error("mode select answer wrong");
  property p_mode_rng;
    req_valid && req_cmd == `SRV_CMD_READ_MODE && req_dno == `SRV_DNO_12 |=> rsp_data <= 32'h4;
  endproperty
  a_mode_rng: assert property (p_mode_rng) else $error("mode read out of range");
  property p_gate; frc_w |-> out_dis_r; endproperty
  a_gate: assert property (p_gate) else $error("forced write before output disable");
  property p_force_ack; frc_w |=> rsp_valid && rsp_data == 32'h0; endproperty
  a_force_ack: assert property (p_force_ack) else $error("forced write answer wrong");
  property p_hist; req_valid && req_cmd == `SRV_CMD_HISTORY |=> rsp_data[31:16] == 16'h0;
  endproperty
  a_hist: assert property (p_hist) else $error("history answer too wide");
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
`include "srv_cmd_map.svh"
module testbench;
  import srv_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        go_in = 1'b0;
  logic [7:0]  cmd_in = 8'h0;
  logic [7:0]  dno_in = 8'h0;
  logic [31:0] data_in = 32'h0;
  logic        emergency_stop_in = 1'b1;
  logic [31:0] ext_di_in = 32'hffffffff;
  logic [15:0] analog_in = 16'h1234;
  logic        pulse_in = 1'b1;
  logic        running_in = 1'b0;
  logic        pos_start_in = 1'b0;
  logic        pos_done_in = 1'b0;
  logic [6:0]  servo_do_in = 7'h55;
  logic        alarm_event_in = 1'b0;
  logic [15:0] alarm_code_in = 16'h0;
  logic [15:0] alarm_hours_in = 16'h0;
  logic [15:0] alarm_now_in = 16'h0032;
  logic        busy_out, refused_out, rsp_valid_out, emg_out, pulse_out, base_off_out;
  logic        decel_stop_out, pos_pause_out, pos_clear_out, rf, seen_clr, bz;
  logic [31:0] rsp_data_out, discrete_inputs_out, r;
  logic [15:0] analog_out;
  logic [6:0]  out_pins_out;
  srv_mode_t   mode_out;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Command, data number, data, expected answer
  logic [79:0] rows [16] = '{
    {8'h8b, 8'h00, 32'h1, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h1},
    {8'h8b, 8'h00, 32'h2, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h2},
    {8'h8b, 8'h00, 32'h3, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h3},
    {8'h8b, 8'h00, 32'h5, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h3},
    {8'h8b, 8'h00, 32'h4, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h4},
    {8'h8b, 8'h00, 32'h0, 32'h0}, {8'h00, 8'h12, 32'h0, 32'h0},
    {8'h33, 8'h10, 32'h0, 32'hff}, {8'h33, 8'h15, 32'h0, 32'hff},
    {8'h33, 8'h25, 32'h0, 32'h0}, {8'h02, 8'h00, 32'h0, 32'h32}
  };

  srv_link_if link ();
  srv_dev #(.SILENCE_CYC(50)) srv_dev_inst (.mclk_in, .rst_in, .link, .emergency_stop_in,
    .ext_di_in, .analog_in, .pulse_in, .running_in, .pos_start_in, .pos_done_in, .servo_do_in,
    .alarm_event_in, .alarm_code_in, .alarm_hours_in, .alarm_now_in, .emg_out,
    .discrete_inputs_out, .analog_out, .pulse_out, .base_off_out, .decel_stop_out,
    .pos_pause_out, .pos_clear_out, .mode_out, .out_pins_out);
  srv_mst srv_mst_inst (.mclk_in, .rst_in, .link, .go_in, .cmd_in, .dno_in, .data_in,
    .busy_out, .refused_out, .rsp_valid_out, .rsp_data_out);
  srv_link_sva srv_link_sva_inst (.mclk_in, .rst_in, .req_valid(link.req_valid),
    .req_cmd(link.req_cmd), .req_dno(link.req_dno), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

  // Free-running clock
  always #5 mclk_in = ~mclk_in;

  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One request through the master; waits long enough for all outputs to settle
  task automatic tx(input logic [7:0] c, input logic [7:0] d, input logic [31:0] w);
    int i;
    cmd_in = c;
    dno_in = d;
    data_in = w;
    go_in = 1'b1;
    @(negedge mclk_in);
    go_in = 1'b0;
    bz = busy_out;
    for (i = 0; i < 8 && rsp_valid_out !== 1'b1 && refused_out !== 1'b1; i++) begin
      @(negedge mclk_in);
      seen_clr |= pos_clear_out;
    end
    if (i == 8) begin
      n_mismatch++;
      finish_test;
    end
    rf = refused_out;
    r = rsp_data_out;
    repeat (3) begin
      @(negedge mclk_in);
      seen_clr |= pos_clear_out;
    end
  endtask

  task automatic ev(input logic [15:0] code, input logic [15:0] hrs);
    alarm_code_in = code;
    alarm_hours_in = hrs;
    alarm_event_in = 1'b1;
    @(negedge mclk_in);
    alarm_event_in = 1'b0;
  endtask

  initial begin
    repeat (6) @(negedge mclk_in);
    rst_in = 1'b0;
    chk(mode_out, SRV_MODE_NORMAL);
    foreach (rows[k]) begin
      tx(rows[k][79:72], rows[k][71:64], rows[k][63:32]);
      chk(r, rows[k][31:0]);
      chk(bz, 1'b1);
    end
    // Input disable, wrong key first
    tx(8'h90, 8'h00, 32'h1ea4);
    chk(discrete_inputs_out, 32'hffffffff);
    tx(8'h90, 8'h00, `SRV_KEY);
    chk(discrete_inputs_out, `SRV_STROKE_BITS);
    chk({analog_out, pulse_out, emg_out}, 32'h1);
    tx(8'h90, 8'h10, `SRV_KEY);
    chk(discrete_inputs_out, 32'hffffffff);
    // Test inputs, coasting entry and silence stop
    ext_di_in = 32'h0;
    running_in = 1'b1;
    tx(8'h8b, 8'h00, 32'h1);
    chk(base_off_out, 1'b1);
    tx(8'h92, 8'h00, 32'hffffffff);
    chk(discrete_inputs_out, `SRV_DI_USED & ~`SRV_STROKE_BITS);
    tx(8'h92, 8'h00, 32'h1);
    repeat (40) @(negedge mclk_in);
    chk(decel_stop_out, 1'b0);
    repeat (15) @(negedge mclk_in);
    chk(decel_stop_out, 1'b1);
    chk(discrete_inputs_out, 32'h1);
    tx(8'h8b, 8'h00, 32'h0);
    chk({base_off_out, decel_stop_out}, 32'h0);
    running_in = 1'b0;
    // Positioning pause, resume and clear
    tx(8'h8b, 8'h00, 32'h2);
    pos_start_in = 1'b1;
    @(negedge mclk_in);
    pos_start_in = 1'b0;
    tx(8'ha0, 8'h41, `SRV_TXT_GO);
    chk(pos_pause_out, 1'b0);
    tx(8'ha0, 8'h41, `SRV_TXT_STOP);
    chk(pos_pause_out, 1'b1);
    tx(8'ha0, 8'h41, `SRV_TXT_GO);
    chk(pos_pause_out, 1'b0);
    tx(8'ha0, 8'h41, `SRV_TXT_STOP);
    seen_clr = 1'b0;
    tx(8'ha0, 8'h41, `SRV_TXT_CLR);
    chk({pos_pause_out, seen_clr}, 32'h1);
    tx(8'ha0, 8'h41, `SRV_TXT_STOP);
    chk(pos_pause_out, 1'b0);
    // Forced outputs, refused until outputs are disabled
    tx(8'h92, 8'ha0, 32'h2a);
    chk({rf, bz}, 32'h2);
    tx(8'h90, 8'h03, `SRV_KEY);
    chk(out_pins_out, 7'h0);
    tx(8'h8b, 8'h00, 32'h4);
    tx(8'h92, 8'ha0, 32'hffffffaa);
    chk(out_pins_out, 7'h2a);
    tx(8'h90, 8'h13, `SRV_KEY);
    tx(8'h8b, 8'h00, 32'h0);
    chk(out_pins_out, servo_do_in);
    // History order, hours and keyed clear
    ev(16'h10, 16'h1f5);
    ev(16'h20, 16'h2);
    tx(8'h33, 8'h10, 32'h0);
    chk(r, 32'h20);
    tx(8'h33, 8'h21, 32'h0);
    chk(r, 32'h1f5);
    tx(8'h82, 8'h20, 32'h1ea4);
    tx(8'h33, 8'h11, 32'h0);
    chk(r, 32'h10);
    tx(8'h82, 8'h20, `SRV_KEY);
    tx(8'h33, 8'h11, 32'h0);
    chk(r, `SRV_NO_ALARM);
    // Reset in mid-run
    tx(8'h8b, 8'h00, 32'h1);
    rst_in = 1'b1;
    @(negedge mclk_in);
    rst_in = 1'b0;
    chk(mode_out, SRV_MODE_NORMAL);
    // Link must work again straight after a mid-run reset
    tx(8'h00, 8'h12, 32'h0);
    chk(r, 32'h0);
    finish_test;
  end
endmodule
